// file: inc/uart_pkg.sv
`default_nettype none
package uart_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [7:0] CTRL_IDX   = 8'h98;
  localparam logic [7:0] DATA_IDX   = 8'h99;
  localparam logic [7:0] RELOAD_IDX = 8'h9A;
  localparam logic [7:0] IRQEN_IDX  = 8'h9B;
  // Reset values
  localparam logic [7:0] CTRL_RST   = 8'h40;
  localparam logic [7:0] DATA_RST   = 8'h00;
  localparam logic [7:0] RELOAD_RST = 8'hF6;
  // Control field positions
  localparam int MODE_BIT   = 7;
  localparam int UNUSED_BIT = 6;
  localparam int FILT_BIT   = 5;
  localparam int REN_BIT    = 4;
  localparam int TB8_BIT    = 3;
  localparam int RB8_BIT    = 2;
  localparam int TI_BIT     = 1;
  localparam int RI_BIT     = 0;
  // Bit times per character
  localparam logic [3:0] BITS_8 = 4'hA;
  localparam logic [3:0] BITS_9 = 4'hB;
  // Baud timer value at which it overflows
  localparam logic [7:0] TMR_TOP = 8'hFF;
  // Transmit states, one-hot
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } tx_state_t;
  // Receive states, one-hot
  typedef enum logic [2:0] {
    RX_IDLE  = 3'b001,
    RX_START = 3'b010,
    RX_DATA  = 3'b100
  } rx_state_t;
endpackage : uart_pkg
`default_nettype wire

// file: inc/serial_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface serial_link_if;
  logic serial_out_line;  // Device transmit, remote receive
  logic serial_in_line;   // Remote transmit, device receive
  // Documented device end
  modport device (output serial_out_line, input serial_in_line);
  // Remote end
  modport remote (input serial_out_line, output serial_in_line);
endinterface : serial_link_if
`default_nettype wire

// file: hdl/serial_port_dev.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1 - control bit 7 selects 8 or 9 bit
// R2 - 8-bit frame: start, 8 LSB-first, stop
// R3 - 8-bit mode: stop level into ninth-receive
// R4 - data buffer write starts transmission
// R5 - transmit done at stop bit start
// R6 - receive only while receive enable set
// R7 - 8-bit load needs free buffer, stop check
// R8 - overrun keeps first byte, drops later
// R9 - on load store byte, ninth, set done
// R10 - failed load changes nothing
// R11 - 9-bit frame: start, 8, ninth, stop
// R12 - ninth transmit bit only in 9-bit mode
// R13 - 9-bit mode: ninth bit stored, stop ignored
// R14 - address filter needs ninth bit one
// R15 - done flags raise enabled interrupt
// R16 - hardware never clears done flags
// R17 - receive done set at stop sample
// R18 - control bit 6 reads one, ignores writes
// R19 - master sends addresses with ninth one
// R20 - bit period is two timer overflows
// R21 - start edge reloads receive timer
// R22 - buffer write to transmit, read receive
// R23 - lines idle high, start low, stop high
// R24 - falling edge start, mid-bit sampling
module serial_port_dev (
  input  wire logic        clk_i,   // System clock
  input  wire logic        rst_i,   // Synchronous reset
  input  wire logic        cyc_i,   // Bus cycle
  input  wire logic        stb_i,   // Bus strobe
  input  wire logic        we_i,    // Write enable
  input  wire logic [9:0]  adr_i,   // Byte address
  input  wire logic [3:0]  sel_i,   // Byte lanes
  input  wire logic [31:0] dat_i,   // Write data
  output logic      [31:0] dat_o,   // Read data
  output logic             ack_o,   // Bus acknowledge
  output logic             irq_o,   // Interrupt request
  serial_link_if.device    link     // Serial lines
);
  logic                  ack_r;     // Bus acknowledge
  logic [31:0]           dat_r;     // Read data
  logic [7:0]            rd_val;    // Read mux
  logic [7:0]            ctrl_val;  // Control read image
  logic                  wr;        // Write takes effect
  logic                  wr_ctrl;   // Control write
  logic                  wr_data;   // Buffer write
  logic                  mode_r;    // Frame width select
  logic                  filt_r;    // Stop check / address filter
  logic                  ren_r;     // Receive enable
  logic                  tb8_r;     // Ninth transmit bit
  logic                  rb8_r;     // Ninth receive bit
  logic                  ti_r;      // Transmit done flag
  logic                  ri_r;      // Receive done flag
  logic                  irqen_r;   // Interrupt enable
  logic                  irq_r;     // Interrupt output
  logic [7:0]            reload_r;  // Baud timer reload
  logic [7:0]            rxbuf_r;   // Receive buffer
  logic [7:0]            tx_tmr_r;  // Transmit baud timer
  logic                  tx_half_r; // Overflow divider
  logic                  tx_tick;   // Transmit bit boundary
  logic [7:0]            rx_tmr_r;  // Receive baud timer
  logic                  rx_half_r; // Overflow divider
  logic                  rx_samp;   // Receive sample point
  uart_pkg::tx_state_t   tx_st_r;   // Transmit state
  logic [10:0]           frame_r;   // Transmit shifter
  logic [3:0]            tx_cnt_r;  // Bits sent
  logic [3:0]            tx_stop;   // Stop bit index
  logic                  tx_nine_r; // Frame width latched
  logic                  set_ti;    // Transmit done event
  logic                  out_r;     // Line driver
  logic                  rx_s1_r;   // Sync stage one
  logic                  rx_s2_r;   // Sync stage two
  logic                  rx_prev_r; // Previous synced level
  logic                  start_det; // Start edge
  uart_pkg::rx_state_t   rx_st_r;   // Receive state
  logic [8:0]            rx_sh_r;   // Receive shifter
  logic [3:0]            rx_cnt_r;  // Bits received
  logic                  rx_last;   // Stop bit sample now
  logic                  ninth_val; // Stop or ninth bit
  logic [7:0]            rx_byte;   // Received byte
  logic                  load_ok;   // Load conditions hold
  logic                  set_ri;    // Receive done event

  // Bus decode; a write lands on the acknowledged edge
  assign wr      = cyc_i & stb_i & we_i & sel_i[0] & ack_r;
  assign wr_ctrl = wr & (adr_i[9:2] == uart_pkg::CTRL_IDX);
  // R22 - writes feed transmitter
  assign wr_data = wr & (adr_i[9:2] == uart_pkg::DATA_IDX);
  assign ack_o   = ack_r;
  assign dat_o   = dat_r;
  assign irq_o   = irq_r;

  // One wait cycle, then acknowledge; drop after one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) ack_r <= 1'b0;
    else       ack_r <= cyc_i & stb_i & ~ack_r;
  end

  // Control image
  always_comb begin
    ctrl_val = 8'h00;
    ctrl_val[uart_pkg::MODE_BIT] = mode_r;
    // R18 - unused bit reads one
    ctrl_val[uart_pkg::UNUSED_BIT] = 1'b1;
    ctrl_val[uart_pkg::FILT_BIT] = filt_r;
    ctrl_val[uart_pkg::REN_BIT] = ren_r;
    ctrl_val[uart_pkg::TB8_BIT] = tb8_r;
    ctrl_val[uart_pkg::RB8_BIT] = rb8_r;
    ctrl_val[uart_pkg::TI_BIT] = ti_r;
    ctrl_val[uart_pkg::RI_BIT] = ri_r;
  end

  // Read mux; unmapped reads as zero
  always_comb begin
    case (adr_i[9:2])
      // R22 - reads return receive buffer
      uart_pkg::DATA_IDX:   rd_val = rxbuf_r;
      uart_pkg::CTRL_IDX:   rd_val = ctrl_val;
      uart_pkg::RELOAD_IDX: rd_val = reload_r;
      uart_pkg::IRQEN_IDX:  rd_val = {7'h00, irqen_r};
      default:              rd_val = 8'h00;
    endcase
  end

  // Read data captured in the wait cycle
  always_ff @(posedge clk_i) begin
    if (rst_i)                         dat_r <= 32'h0000_0000;
    else if (cyc_i & stb_i & ~ack_r)   dat_r <= {24'h000000, rd_val};
  end

  // Software-owned control bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= uart_pkg::CTRL_RST[uart_pkg::MODE_BIT];
      filt_r <= uart_pkg::CTRL_RST[uart_pkg::FILT_BIT];
      ren_r  <= uart_pkg::CTRL_RST[uart_pkg::REN_BIT];
      tb8_r  <= uart_pkg::CTRL_RST[uart_pkg::TB8_BIT];
    end else if (wr_ctrl) begin
      // R1 - mode bit
      mode_r <= dat_i[uart_pkg::MODE_BIT];
      filt_r <= dat_i[uart_pkg::FILT_BIT];
      ren_r  <= dat_i[uart_pkg::REN_BIT];
      tb8_r  <= dat_i[uart_pkg::TB8_BIT];
    end
  end

  // Own registers: baud reload and interrupt enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reload_r <= uart_pkg::RELOAD_RST;
      irqen_r  <= 1'b0;
    end else begin
      if (wr & (adr_i[9:2] == uart_pkg::RELOAD_IDX)) reload_r <= dat_i[7:0];
      if (wr & (adr_i[9:2] == uart_pkg::IRQEN_IDX))  irqen_r  <= dat_i[0];
    end
  end

  // Done flags; a hardware set beats a software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ti_r <= uart_pkg::CTRL_RST[uart_pkg::TI_BIT];
      ri_r <= uart_pkg::CTRL_RST[uart_pkg::RI_BIT];
    end else begin
      // R16 - only software clears
      ti_r <= set_ti | (wr_ctrl ? dat_i[uart_pkg::TI_BIT] : ti_r);
      ri_r <= set_ri | (wr_ctrl ? dat_i[uart_pkg::RI_BIT] : ri_r);
    end
  end

  // Interrupt request
  always_ff @(posedge clk_i) begin
    // R15 - enabled done flags
    if (rst_i) irq_r <= 1'b0;
    else       irq_r <= irqen_r & (ti_r | ri_r);
  end

  // Transmit baud timer, restarted by a buffer write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_tmr_r  <= uart_pkg::RELOAD_RST;
      tx_half_r <= 1'b0;
    end else if (wr_data) begin
      tx_tmr_r  <= reload_r;
      tx_half_r <= 1'b0;
    end else if (tx_tmr_r == uart_pkg::TMR_TOP) begin
      tx_tmr_r  <= reload_r;
      tx_half_r <= ~tx_half_r;
    end else begin
      tx_tmr_r  <= tx_tmr_r + 8'h01;
    end
  end
  // R20 - two overflows per bit
  assign tx_tick = (tx_tmr_r == uart_pkg::TMR_TOP) & tx_half_r;

  // Stop bit position for the frame in flight
  assign tx_stop = (tx_nine_r ? uart_pkg::BITS_9 : uart_pkg::BITS_8) - 4'h1;
  // R5 - done at stop start
  assign set_ti  = (tx_st_r == uart_pkg::TX_SEND) & tx_tick
                 & (tx_cnt_r + 4'h1 == tx_stop);

  // Transmit sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_st_r   <= uart_pkg::TX_IDLE;
      frame_r   <= 11'h7FF;
      tx_cnt_r  <= 4'h0;
      tx_nine_r <= 1'b0;
    end else if (wr_data) begin
      // R4 - write starts frame
      tx_st_r   <= uart_pkg::TX_SEND;
      tx_cnt_r  <= 4'h0;
      tx_nine_r <= mode_r;
      // R2 R11 R12 R23 - frame layout
      frame_r   <= mode_r ? {1'b1, tb8_r, dat_i[7:0], 1'b0}
                          : {2'b11, dat_i[7:0], 1'b0};
    end else begin
      case (tx_st_r)
        uart_pkg::TX_SEND: begin
          if (tx_tick) begin
            frame_r  <= {1'b1, frame_r[10:1]};
            tx_cnt_r <= tx_cnt_r + 4'h1;
            if (tx_cnt_r == tx_stop) tx_st_r <= uart_pkg::TX_IDLE;
          end
        end
        uart_pkg::TX_IDLE: tx_st_r <= uart_pkg::TX_IDLE;
        default:           tx_st_r <= uart_pkg::TX_IDLE;
      endcase
    end
  end

  // Line driver, idles high
  always_ff @(posedge clk_i) begin
    if (rst_i) out_r <= 1'b1;
    else       out_r <= frame_r[0];
  end
  assign link.serial_out_line = out_r;

  // Receive line synchroniser and edge history
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_s1_r   <= 1'b1;
      rx_s2_r   <= 1'b1;
      rx_prev_r <= 1'b1;
    end else begin
      rx_s1_r   <= link.serial_in_line;
      rx_s2_r   <= rx_s1_r;
      rx_prev_r <= rx_s2_r;
    end
  end
  // R24 - falling edge start
  assign start_det = (rx_st_r == uart_pkg::RX_IDLE) & ren_r & rx_prev_r & ~rx_s2_r;

  // Receive baud timer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_tmr_r  <= uart_pkg::RELOAD_RST;
      rx_half_r <= 1'b0;
    end else if (start_det) begin
      // R21 - reload on start
      rx_tmr_r  <= reload_r;
      rx_half_r <= 1'b0;
    end else if (rx_tmr_r == uart_pkg::TMR_TOP) begin
      rx_tmr_r  <= reload_r;
      rx_half_r <= ~rx_half_r;
    end else begin
      rx_tmr_r  <= rx_tmr_r + 8'h01;
    end
  end
  // R20 R24 - odd overflows, mid-bit
  assign rx_samp = (rx_tmr_r == uart_pkg::TMR_TOP) & ~rx_half_r;

  // Stop sample decode
  assign rx_last   = (rx_st_r == uart_pkg::RX_DATA) & rx_samp
                   & (rx_cnt_r == (mode_r ? 4'h9 : 4'h8));
  // R3 R13 - stop or ninth
  assign ninth_val = mode_r ? rx_sh_r[8] : rx_s2_r;
  assign rx_byte   = mode_r ? rx_sh_r[7:0] : rx_sh_r[8:1];
  // R7 R8 R14 - load conditions
  assign load_ok   = ~ri_r & (~filt_r | ninth_val);
  // R17 - set at stop sample
  assign set_ri    = rx_last & load_ok;

  // Receive sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_st_r  <= uart_pkg::RX_IDLE;
      rx_sh_r  <= 9'h000;
      rx_cnt_r <= 4'h0;
    end else if (~ren_r) begin
      // R6 - disabled receiver idles
      rx_st_r  <= uart_pkg::RX_IDLE;
    end else begin
      case (rx_st_r)
        uart_pkg::RX_IDLE:
          if (start_det) rx_st_r <= uart_pkg::RX_START;
        uart_pkg::RX_START:
          if (rx_samp) begin
            rx_cnt_r <= 4'h0;
            rx_st_r  <= rx_s2_r ? uart_pkg::RX_IDLE : uart_pkg::RX_DATA;
          end
        uart_pkg::RX_DATA:
          if (rx_last) begin
            rx_st_r <= uart_pkg::RX_IDLE;
          end else if (rx_samp) begin
            rx_sh_r  <= {rx_s2_r, rx_sh_r[8:1]};
            rx_cnt_r <= rx_cnt_r + 4'h1;
          end
        default: rx_st_r <= uart_pkg::RX_IDLE;
      endcase
    end
  end

  // Receive buffer and ninth bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxbuf_r <= uart_pkg::DATA_RST;
      rb8_r   <= uart_pkg::CTRL_RST[uart_pkg::RB8_BIT];
    end else if (set_ri) begin
      // R9 - store on load
      rxbuf_r <= rx_byte;
      rb8_r   <= ninth_val;
    end else if (wr_ctrl) begin
      // R10 - else untouched by hardware
      rb8_r   <= dat_i[uart_pkg::RB8_BIT];
    end
  end
endmodule : serial_port_dev
`default_nettype wire

// file: hdl/serial_port_remote.sv
`timescale 1ns/1ps
`default_nettype none
module serial_port_remote (
  input  wire logic       clk_i,          // System clock
  input  wire logic       rst_i,          // Synchronous reset
  input  wire logic       nine_bit_i,     // 9-bit frames
  input  wire logic [7:0] baud_reload_i,  // Same reload as device
  input  wire logic       send_valid_i,   // Send request
  input  wire logic [7:0] send_data_i,    // Byte to send
  input  wire logic       send_ninth_i,   // Ninth bit to send
  output logic            send_ready_o,   // Transmitter idle
  output logic            recv_valid_o,   // Character received
  output logic      [7:0] recv_data_o,    // Received byte
  output logic            recv_ninth_o,   // Ninth bit or stop
  output logic            recv_stop_o,    // Stop bit level
  serial_link_if.remote   link            // Serial lines
);
  logic [9:0]          per;        // Cycles per bit
  uart_pkg::tx_state_t tx_st_r;    // Transmit state
  logic [10:0]         frame_r;    // Transmit shifter
  logic [9:0]          tx_tmr_r;   // Transmit bit timer
  logic [3:0]          tx_cnt_r;   // Bits sent
  logic [3:0]          tx_stop;    // Stop bit index
  logic                tx_nine_r;  // Frame width latched
  logic                out_r;      // Line driver
  logic                rx_s1_r;    // Sync stage one
  logic                rx_s2_r;    // Sync stage two
  logic                rx_prev_r;  // Previous level
  uart_pkg::rx_state_t rx_st_r;    // Receive state
  logic [9:0]          rx_tmr_r;   // Receive bit timer
  logic [3:0]          rx_cnt_r;   // Bits received
  logic [8:0]          rx_sh_r;    // Receive shifter
  logic                rx_samp;    // Sample point
  logic                val_r;      // Receive pulse
  logic [7:0]          data_r;     // Received byte
  logic                ninth_r;    // Ninth or stop
  logic                stop_r;     // Stop level

  // Two timer overflows of (256 - reload) cycles per bit
  assign per = 10'(({2'h0, ~baud_reload_i} + 10'h001) << 1);
  assign send_ready_o = (tx_st_r == uart_pkg::TX_IDLE);
  assign tx_stop = (tx_nine_r ? uart_pkg::BITS_9 : uart_pkg::BITS_8) - 4'h1;
  assign recv_valid_o = val_r;
  assign recv_data_o  = data_r;
  assign recv_ninth_o = ninth_r;
  assign recv_stop_o  = stop_r;

  // Transmit sequencer, full bit times
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_st_r   <= uart_pkg::TX_IDLE;
      frame_r   <= 11'h7FF;
      tx_tmr_r  <= 10'h000;
      tx_cnt_r  <= 4'h0;
      tx_nine_r <= 1'b0;
    end else begin
      case (tx_st_r)
        uart_pkg::TX_IDLE:
          if (send_valid_i) begin
            tx_st_r   <= uart_pkg::TX_SEND;
            tx_tmr_r  <= 10'h000;
            tx_cnt_r  <= 4'h0;
            tx_nine_r <= nine_bit_i;
            // R19 - ninth bit from user
            frame_r   <= nine_bit_i ? {1'b1, send_ninth_i, send_data_i, 1'b0}
                                    : {2'b11, send_data_i, 1'b0};
          end
        uart_pkg::TX_SEND:
          if (tx_tmr_r == per - 10'h001) begin
            tx_tmr_r <= 10'h000;
            frame_r  <= {1'b1, frame_r[10:1]};
            tx_cnt_r <= tx_cnt_r + 4'h1;
            if (tx_cnt_r == tx_stop) tx_st_r <= uart_pkg::TX_IDLE;
          end else begin
            tx_tmr_r <= tx_tmr_r + 10'h001;
          end
        default: tx_st_r <= uart_pkg::TX_IDLE;
      endcase
    end
  end

  // Line driver, idles high
  always_ff @(posedge clk_i) begin
    // R23 - idle high
    if (rst_i) out_r <= 1'b1;
    else       out_r <= frame_r[0];
  end
  assign link.serial_in_line = out_r;

  // Line synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_s1_r   <= 1'b1;
      rx_s2_r   <= 1'b1;
      rx_prev_r <= 1'b1;
    end else begin
      rx_s1_r   <= link.serial_out_line;
      rx_s2_r   <= rx_s1_r;
      rx_prev_r <= rx_s2_r;
    end
  end

  // Sample half a bit after the edge, then every bit
  assign rx_samp = (rx_st_r == uart_pkg::RX_START) ? (rx_tmr_r == (per >> 1))
                                                   : (rx_tmr_r == per - 10'h001);

  // Receive sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_st_r  <= uart_pkg::RX_IDLE;
      rx_tmr_r <= 10'h000;
      rx_cnt_r <= 4'h0;
      rx_sh_r  <= 9'h000;
    end else begin
      rx_tmr_r <= rx_samp ? 10'h000 : rx_tmr_r + 10'h001;
      case (rx_st_r)
        uart_pkg::RX_IDLE:
          if (rx_prev_r & ~rx_s2_r) begin
            rx_st_r  <= uart_pkg::RX_START;
            rx_tmr_r <= 10'h000;
          end
        uart_pkg::RX_START:
          if (rx_samp) begin
            rx_cnt_r <= 4'h0;
            rx_st_r  <= rx_s2_r ? uart_pkg::RX_IDLE : uart_pkg::RX_DATA;
          end
        uart_pkg::RX_DATA:
          if (rx_samp) begin
            // R2 R11 - LSB first
            rx_sh_r  <= {rx_s2_r, rx_sh_r[8:1]};
            rx_cnt_r <= rx_cnt_r + 4'h1;
            if (rx_cnt_r == (nine_bit_i ? 4'h9 : 4'h8)) rx_st_r <= uart_pkg::RX_IDLE;
          end
        default: rx_st_r <= uart_pkg::RX_IDLE;
      endcase
    end
  end

  // Received character outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      val_r   <= 1'b0;
      data_r  <= 8'h00;
      ninth_r <= 1'b0;
      stop_r  <= 1'b0;
    end else begin
      val_r <= (rx_st_r == uart_pkg::RX_DATA) & rx_samp
             & (rx_cnt_r == (nine_bit_i ? 4'h9 : 4'h8));
      if ((rx_st_r == uart_pkg::RX_DATA) & rx_samp
          & (rx_cnt_r == (nine_bit_i ? 4'h9 : 4'h8))) begin
        data_r  <= nine_bit_i ? rx_sh_r[7:0] : rx_sh_r[8:1];
        ninth_r <= nine_bit_i ? rx_sh_r[8] : rx_s2_r;
        stop_r  <= rx_s2_r;
      end
    end
  end
endmodule : serial_port_remote
`default_nettype wire

// file: verif/serial_port_checker.sv
`timescale 1ns/1ps
`default_nettype none
module serial_port_checker #(
  parameter int BIT_CLK = 20  // Clocks per bit at the reset reload
) (
  input  wire logic clk_i,            // System clock
  input  wire logic rst_i,            // Synchronous reset
  input  wire logic serial_out_line,  // Device transmit line
  input  wire logic serial_in_line    // Remote transmit line
);
  logic [7:0] out_lo_r, out_hi_r;  // Run lengths on the transmit line
  logic [7:0] in_lo_r, in_hi_r;    // Run lengths on the receive line
  default clocking cb @(posedge clk_i); endclocking
  // Saturating low and high run counters, device side
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_lo_r <= 8'h00;
      out_hi_r <= 8'hFF;
    end else begin
      out_lo_r <= serial_out_line ? 8'h00 : out_lo_r + {7'h00, out_lo_r != 8'hFF};
      out_hi_r <= serial_out_line ? out_hi_r + {7'h00, out_hi_r != 8'hFF} : 8'h00;
    end
  end
  // Saturating low and high run counters, remote side
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_lo_r <= 8'h00;
      in_hi_r <= 8'hFF;
    end else begin
      in_lo_r <= serial_in_line ? 8'h00 : in_lo_r + {7'h00, in_lo_r != 8'hFF};
      in_hi_r <= serial_in_line ? in_hi_r + {7'h00, in_hi_r != 8'hFF} : 8'h00;
    end
  end
  a_out_idle_reset: assert property (rst_i |=> serial_out_line)
    else $error("transmit line not idle high after reset");
  a_in_idle_reset: assert property (rst_i |=> serial_in_line)
    else $error("receive line not idle high after reset");
  a_out_bit_whole: assert property (disable iff (rst_i)
    $rose(serial_out_line) |-> (out_lo_r % BIT_CLK) == 0)
    else $error("transmit low run not whole bit times");
  a_in_bit_whole: assert property (disable iff (rst_i)
    $rose(serial_in_line) |-> (in_lo_r % BIT_CLK) == 0)
    else $error("receive low run not whole bit times");
  a_out_low_bound: assert property (disable iff (rst_i)
    $rose(serial_out_line) |-> out_lo_r <= 8'hC8)
    else $error("transmit line low beyond a frame");
  a_in_low_bound: assert property (disable iff (rst_i)
    $rose(serial_in_line) |-> in_lo_r <= 8'hC8)
    else $error("receive line low beyond a frame");
  a_out_stop_high: assert property (disable iff (rst_i)
    $fell(serial_out_line) |-> out_hi_r >= 8'h14)
    else $error("transmit start without a full stop bit");
  a_in_stop_high: assert property (disable iff (rst_i)
    $fell(serial_in_line) |-> in_hi_r >= 8'h14)
    else $error("receive start without a full stop bit");
endmodule : serial_port_checker
`default_nettype wire

// file: verif/async_serial_port_8n1_9bit_bench.sv
`timescale 1ns/1ps
`default_nettype none
module async_serial_port_8n1_9bit_bench;
  localparam logic [7:0] C = uart_pkg::CTRL_IDX;  // Control index
  localparam logic [7:0] D = uart_pkg::DATA_IDX;  // Data buffer index
  // Transmit cases: control, byte, expected ninth
  localparam logic [7:0] TXC [3] = '{8'h00, 8'h88, 8'h80};
  localparam logic [7:0] TXD [3] = '{8'hA5, 8'h3C, 8'hC3};
  localparam logic       TXN [3] = '{1'b1, 1'b1, 1'b0};
  // Receive cases: control, byte, ninth sent, expected control and buffer
  localparam logic [7:0] RXC [6] = '{8'h10, 8'h11, 8'h00, 8'hB0, 8'hB0, 8'h94};
  localparam logic [7:0] RXD [6] = '{8'h3C, 8'h77, 8'h77, 8'h5A, 8'h5A, 8'h81};
  localparam logic       RXN [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  localparam logic [7:0] EXC [6] = '{8'h55, 8'h51, 8'h40, 8'hF0, 8'hF5, 8'hD1};
  localparam logic [7:0] EXD [6] = '{8'h3C, 8'h3C, 8'h3C, 8'h3C, 8'h5A, 8'h81};
  logic        clk_i, rst_i;            // Clock and reset
  logic        cyc, stb, we, ack, irq;  // Bus controls
  logic [9:0]  adr;                     // Bus address
  logic [31:0] wdat, rdat;              // Bus data
  logic        nine, svalid, sninth;    // Remote controls
  logic [7:0]  sdata, rdata;            // Remote data
  logic        sready, rvalid, rninth, rstop;  // Remote status
  int          errors, total_checks, rcount, cycles;  // Counters
  serial_link_if link ();
  serial_port_dev serial_port_dev_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .irq_o(irq), .link(link.device));
  serial_port_remote serial_port_remote_i (.clk_i(clk_i), .rst_i(rst_i), .nine_bit_i(nine),
    .baud_reload_i(uart_pkg::RELOAD_RST), .send_valid_i(svalid), .send_data_i(sdata),
    .send_ninth_i(sninth), .send_ready_o(sready), .recv_valid_o(rvalid),
    .recv_data_o(rdata), .recv_ninth_o(rninth), .recv_stop_o(rstop), .link(link.remote));
  serial_port_checker serial_port_checker_i (.clk_i(clk_i), .rst_i(rst_i),
    .serial_out_line(link.serial_out_line), .serial_in_line(link.serial_in_line));
  // Clock, 25 ns period
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Count remote receptions and cut a hang short
  always @(posedge clk_i) begin
    if (rvalid === 1'b1) rcount <= rcount + 1;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      results();
    end
  end
  // Compare and count
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // One classic Wishbone cycle, waits for ack
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                    output logic [7:0] rd);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h000000, wd};
    // Ends on ack; the bench timeout is its only limit
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] x;
    wb(1'b1, idx, wd, x);
  endtask : wr
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp, input string nm);
    logic [7:0] v;
    wb(1'b0, idx, 8'h00, v);
    check(nm, v, exp);
  endtask : rdchk
  // Remote sends one character and waits until its line is idle again
  task automatic rsend(input logic [7:0] d, input logic n9);
    @(posedge clk_i);
    sdata <= d;
    sninth <= n9;
    svalid <= 1'b1;
    @(posedge clk_i);
    svalid <= 1'b0;
    do @(posedge clk_i); while (sready !== 1'b1);
    repeat (4) @(posedge clk_i);
  endtask : rsend
  // Closing report
  task automatic results();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  // Main sequence
  initial begin
    int n, rc;
    logic [7:0] v;
    {errors, total_checks, rcount, cycles} = '0;
    {rst_i, cyc, stb, we, adr, wdat} = {1'b1, 45'h0};
    {nine, svalid, sninth, sdata} = 11'h000;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(C, uart_pkg::CTRL_RST, "ctrl");
    rdchk(D, uart_pkg::DATA_RST, "rxbuf");
    rdchk(uart_pkg::RELOAD_IDX, uart_pkg::RELOAD_RST, "reload");
    rdchk(8'h10, 8'h00, "unmapped");
    wr(C, 8'h00);
    rdchk(C, 8'h40, "ctrl_b6");
    $display("test registers done");
    wr(uart_pkg::IRQEN_IDX, 8'h01);
    for (int i = 0; i < 3; i++) begin
      nine <= TXC[i][7];
      wr(C, TXC[i]);
      rc = rcount;
      wr(D, TXD[i]);
      n = 0;
      do wb(1'b0, C, 8'h00, v); while (v[1] !== 1'b1 && ++n < 200);
      check("tx_done_early", {7'h00, rcount == rc}, 8'h01);
      check("irq_set", {7'h00, irq}, 8'h01);
      n = 0;
      while (rcount == rc && n < 400) begin
        @(posedge clk_i);
        n++;
      end
      check("tx_data", rdata, TXD[i]);
      check("tx_ninth", {7'h00, rninth}, {7'h00, TXN[i]});
      check("tx_stop", {7'h00, rstop}, 8'h01);
      rdchk(C, TXC[i] | 8'h42, "tx_done_kept");
      wr(C, TXC[i]);
      // Flag clears at the ack edge, the request follows one edge later
      repeat (2) @(posedge clk_i);
      check("irq_clear", {7'h00, irq}, 8'h00);
      repeat (20) @(posedge clk_i);
    end
    $display("test transmit done");
    for (int i = 0; i < 6; i++) begin
      nine <= RXC[i][7];
      wr(C, RXC[i]);
      rsend(RXD[i], RXN[i]);
      rdchk(C, EXC[i], "rx_ctrl");
      rdchk(D, EXD[i], "rx_buf");
    end
    $display("test receive done");
    results();
  end
endmodule : async_serial_port_8n1_9bit_bench
`default_nettype wire
